// ### core/scrsw_host.sv
`timescale 1ns/1ps
`default_nettype none
module scrsw_host
    import scrsw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    scrsw_if.host link,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    // ****************************************
    // Registers
    // ****************************************
    logic [15:0] sel_r;
    logic [SCRSW_TRIG_N-1:0] trig_r;
    logic [SCRSW_ST_W-1:0] status_r;
    logic [SCRSW_ST_W-1:0] mask_r;
    logic strobe_d_r;
    logic ack_r;
    logic wr_en;
    logic rd_en;
    logic strobe_rise;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign strobe_rise = link.switch_strobe && !strobe_d_r;

    // Software writes; reselect needs another screen shown first, selected from software or switched in by a trigger
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_r <= SCRSW_SCR_NONE;
            trig_r <= '0;
            mask_r <= '0;
        end else begin
            if (wr_en) begin
                case (paddr)
                    SCRSW_REG_SELECT: sel_r <= pwdata[15:0];
                    SCRSW_REG_TRIG: trig_r <= pwdata[SCRSW_TRIG_N-1:0];
                    SCRSW_REG_MASK: mask_r <= pwdata[SCRSW_ST_W-1:0];
                    default: ;
                endcase
            end
            // Copy of a switch beats a same-cycle select write; other registers still land
            if (strobe_rise) begin
                sel_r <= link.current_word;
            end
        end
    end

    // Sticky switch event, write one to clear, set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r <= '0;
            strobe_d_r <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            strobe_d_r <= link.switch_strobe;
            ack_r <= strobe_rise;
            if (strobe_rise) begin
                status_r[SCRSW_ST_SWITCH] <= 1'b1;
            end else if (wr_en && paddr == SCRSW_REG_STATUS) begin
                status_r <= status_r & ~pwdata[SCRSW_ST_W-1:0];
            end
        end
    end

    // APB answer, zero wait, registered read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= SCRSW_DATA_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == SCRSW_REG_SELECT || paddr == SCRSW_REG_TRIG
                || paddr == SCRSW_REG_CURRENT || paddr == SCRSW_REG_STATUS || paddr == SCRSW_REG_MASK);
            prdata <= SCRSW_DATA_ZERO;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    SCRSW_REG_SELECT: prdata <= {16'h0000, sel_r};
                    SCRSW_REG_TRIG: prdata <= {{(32-SCRSW_TRIG_N){1'b0}}, trig_r};
                    SCRSW_REG_CURRENT: prdata <= {16'h0000, link.current_word};
                    SCRSW_REG_STATUS: prdata <= {{(32-SCRSW_ST_W){1'b0}}, status_r};
                    SCRSW_REG_MASK: prdata <= {{(32-SCRSW_ST_W){1'b0}}, mask_r};
                    default: prdata <= SCRSW_DATA_ZERO;
                endcase
            end
        end
    end
    assign link.select_word = sel_r;
    assign link.trig_bits = trig_r;
    assign link.notify_ack = ack_r;
endmodule
`default_nettype wire

// ### core/scrsw_if.sv
`timescale 1ns/1ps
`default_nettype none
// Shared host words between controller and terminal
interface scrsw_if;
    import scrsw_pkg::*;
    logic [15:0] select_word;
    logic [SCRSW_TRIG_N-1:0] trig_bits;
    logic [15:0] current_word;
    logic switch_strobe;
    logic notify_ack;
    modport terminal (
        input select_word,
        input trig_bits,
        input notify_ack,
        output current_word,
        output switch_strobe
    );
    modport host (
        output select_word,
        output trig_bits,
        output notify_ack,
        input current_word,
        input switch_strobe
    );
endinterface
`default_nettype wire

// ### core/scrsw_pkg.sv
package scrsw_pkg;
    // ****************************************
    // Widths and counts
    // ****************************************
    localparam int SCRSW_NUM_W = 16;
    localparam int SCRSW_TRIG_N = 8;
    localparam int SCRSW_POLL_DIV = 16;
    localparam logic [3:0] SCRSW_POLL_LAST = 4'(SCRSW_POLL_DIV - 1);
    localparam logic [3:0] SCRSW_NOTIFY_HOLD = 4'hF;

    // ****************************************
    // Screen numbers (BCD)
    // ****************************************
    localparam logic [15:0] SCRSW_SCR_NONE = 16'h0000;
    localparam logic [15:0] SCRSW_SCR_HIST_OCC = 16'h1997;
    localparam logic [15:0] SCRSW_SCR_HIST_FREQ = 16'h1998;
    localparam logic [15:0] SCRSW_SCR_HOST_CONN = 16'h1999;
    localparam logic [15:0] SCRSW_TRIG_SCR_BASE = 16'h1000;

    // ****************************************
    // Display kinds
    // ****************************************
    typedef enum logic [2:0] {
        SCRSW_SHOW_BLANK,
        SCRSW_SHOW_NORMAL,
        SCRSW_SHOW_GROUP,
        SCRSW_SHOW_HIST_OCC,
        SCRSW_SHOW_HIST_FREQ,
        SCRSW_SHOW_HOST_CONN,
        SCRSW_SHOW_INVALID
    } scrsw_show_e;

    // ****************************************
    // Host APB register offsets
    // ****************************************
    localparam logic [7:0] SCRSW_REG_SELECT = 8'h00;
    localparam logic [7:0] SCRSW_REG_TRIG = 8'h04;
    localparam logic [7:0] SCRSW_REG_CURRENT = 8'h08;
    localparam logic [7:0] SCRSW_REG_STATUS = 8'h0C;
    localparam logic [7:0] SCRSW_REG_MASK = 8'h10;
    localparam logic [31:0] SCRSW_DATA_ZERO = 32'h0000_0000;
    localparam int SCRSW_ST_SWITCH = 0;
    localparam int SCRSW_ST_W = 1;
endpackage

// ### core/scrsw_terminal.sv
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module scrsw_terminal
    import scrsw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    scrsw_if.terminal link,
    input wire logic [SCRSW_TRIG_N*SCRSW_NUM_W-1:0] trig_screen,
    input wire logic [SCRSW_NUM_W-1:0] group_parent,
    input wire logic [SCRSW_NUM_W-1:0] group_last,
    output logic [SCRSW_NUM_W-1:0] shown_screen,
    output scrsw_show_e shown_kind,
    output logic switch_pulse
);
    // ****************************************
    // Polling divider
    // ****************************************
    logic [3:0] poll_cnt_r;
    logic poll_en;
    // Polling spaced out, like the terminal's scan loop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            poll_cnt_r <= '0;
        end else if (poll_cnt_r == SCRSW_POLL_LAST) begin
            poll_cnt_r <= '0;
        end else begin
            poll_cnt_r <= poll_cnt_r + 4'h1;
        end
    end
    assign poll_en = (poll_cnt_r == SCRSW_POLL_LAST);

    // ****************************************
    // Change and edge detection
    // ****************************************
    logic [SCRSW_NUM_W-1:0] sel_prev_r;
    logic [SCRSW_TRIG_N-1:0] trig_prev_r;
    logic started_r;
    logic sel_change;
    logic [SCRSW_TRIG_N-1:0] trig_rise;
    // Previous samples, kept per poll
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_prev_r <= SCRSW_SCR_NONE;
            trig_prev_r <= '0;
            started_r <= 1'b0;
        end else if (poll_en) begin
            sel_prev_r <= link.select_word;
            trig_prev_r <= link.trig_bits;
            started_r <= 1'b1;
        end
    end
    // First poll takes the select word as start-up screen
    // A select word that already names the shown screen is no request: the host's
    // copy after a trigger switch must not switch the same screen a second time
    assign sel_change = poll_en && (!started_r || (link.select_word != sel_prev_r
        && link.select_word != shown_screen));
    assign trig_rise = link.trig_bits & ~trig_prev_r;

    // ****************************************
    // Screen choice
    // ****************************************
    logic [SCRSW_NUM_W-1:0] new_scr;
    logic new_valid;
    // Lowest trigger index wins; select word wins over triggers
    always_comb begin
        new_scr = SCRSW_SCR_NONE;
        new_valid = 1'b0;
        if (poll_en && started_r) begin
            for (int i = SCRSW_TRIG_N - 1; i >= 0; i--) begin
                if (trig_rise[i]) begin
                    new_scr = trig_screen[i*SCRSW_NUM_W +: SCRSW_NUM_W];
                    new_valid = 1'b1;
                end
            end
        end
        if (sel_change) begin
            new_scr = link.select_word;
            new_valid = 1'b1;
        end
    end

    // Classify a BCD screen number
    function automatic scrsw_show_e classify(input logic [15:0] n);
        logic bad;
        bad = 1'b0;
        for (int d = 0; d < 4; d++) begin
            if (n[d*4 +: 4] > 4'h9) begin
                bad = 1'b1;
            end
        end
        if (bad) begin
            classify = SCRSW_SHOW_INVALID;
        end else if (n == SCRSW_SCR_NONE) begin
            classify = SCRSW_SHOW_BLANK;
        end else if (n == SCRSW_SCR_HIST_OCC) begin
            classify = SCRSW_SHOW_HIST_OCC;
        end else if (n == SCRSW_SCR_HIST_FREQ) begin
            classify = SCRSW_SHOW_HIST_FREQ;
        end else if (n == SCRSW_SCR_HOST_CONN) begin
            classify = SCRSW_SHOW_HOST_CONN;
        end else if (n == group_parent) begin
            classify = SCRSW_SHOW_GROUP;
        end else if (n > group_parent && n <= group_last) begin
            classify = SCRSW_SHOW_NORMAL;
        end else begin
            classify = SCRSW_SHOW_NORMAL;
        end
    endfunction

    // ****************************************
    // Display state
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shown_screen <= SCRSW_SCR_NONE;
            shown_kind <= SCRSW_SHOW_BLANK;
            switch_pulse <= 1'b0;
        end else begin
            switch_pulse <= new_valid;
            if (new_valid) begin
                shown_screen <= new_scr;
                shown_kind <= classify(new_scr);
            end
        end
    end

    // ****************************************
    // Report words
    // ****************************************
    logic [3:0] hold_r;
    logic [SCRSW_NUM_W-1:0] cur_r;
    logic strobe_r;
    // Strobe held until host acks or hold expires; set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_r <= SCRSW_SCR_NONE;
            strobe_r <= 1'b0;
            hold_r <= '0;
        end else if (new_valid) begin
            cur_r <= new_scr;
            strobe_r <= 1'b1;
            hold_r <= SCRSW_NOTIFY_HOLD;
        end else if (strobe_r && (link.notify_ack || hold_r == 4'h0)) begin
            strobe_r <= 1'b0;
        end else if (strobe_r) begin
            hold_r <= hold_r - 4'h1;
        end
    end
    // Group reports its parent number; a child reports its own
    assign link.current_word = cur_r;
    assign link.switch_strobe = strobe_r;
endmodule
`default_nettype wire

// ### test/scrsw_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Link checks between the two ends
// ****
module scrsw_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] select_word,
    input wire logic [7:0] trig_bits,
    input wire logic [15:0] current_word,
    input wire logic switch_strobe,
    input wire logic notify_ack
);
    logic [4:0] gap_r;
    logic [4:0] hold_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles since last switch, saturating so idle spans never wrap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) gap_r <= 5'h1F;
        else if ($rose(switch_strobe)) gap_r <= 5'h00;
        else if (gap_r != 5'h1F) gap_r <= gap_r + 5'h01;
    end
    // Length of the present strobe; a stuck strobe would hide later switches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) hold_r <= 5'h00;
        else if (!switch_strobe) hold_r <= 5'h00;
        else if (hold_r != 5'h1F) hold_r <= hold_r + 5'h01;
    end
    cur_strobe_a: assert property ($changed(current_word) |-> switch_strobe)
        else $error("current word moved without strobe");
    ack_follow_a: assert property ($rose(switch_strobe) |-> ##[0:2] notify_ack)
        else $error("strobe not acknowledged");
    strobe_clear_a: assert property (notify_ack |-> ##[0:2] !switch_strobe)
        else $error("strobe kept after ack");
    strobe_hold_a: assert property (switch_strobe |-> hold_r <= 5'h11)
        else $error("strobe stands too long");
    ack_pulse_a: assert property (notify_ack |=> !notify_ack)
        else $error("ack longer than one cycle");
    poll_gap_a: assert property ($rose(switch_strobe) |-> gap_r >= 5'h0F)
        else $error("switches closer than one poll");
    host_copy_a: assert property ($rose(switch_strobe) |-> ##[1:3] select_word == current_word)
        else $error("host did not copy current screen");
    sel_follow_a: assert property ($changed(select_word) |-> ##[1:18] current_word == select_word)
        else $error("select change not followed");
    cover property ($rose(switch_strobe) && current_word == 16'h0000);
    cover property ($rose(switch_strobe) && trig_bits != 8'h00);
    cover property ($rose(switch_strobe) && current_word == 16'h1999);
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import scrsw_pkg::*;
;
    localparam logic [127:0] TRIG_SCR = 128'h1007_1006_1005_1004_1003_1002_1001_1000;
    localparam logic [15:0] GRP = 16'h0300;
    localparam logic [15:0] TBL [7] = '{16'h0000, 16'h1997, 16'h1998, 16'h1999, 16'h0300, 16'h0301, 16'h12A4};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [15:0] shown_screen;
    scrsw_show_e shown_kind;
    logic switch_pulse;
    logic [31:0] rd;
    logic se;
    int err_count = 0;
    int total_checks = 0;
    int pulses = 0;
    int p0;
    // ****
    // Structure
    // ****
    scrsw_if u_scrsw_if ();
    scrsw_terminal u_scrsw_terminal (.clk(clk), .rst(rst), .link(u_scrsw_if), .trig_screen(TRIG_SCR),
        .group_parent(GRP), .group_last(16'h0302), .shown_screen(shown_screen), .shown_kind(shown_kind),
        .switch_pulse(switch_pulse));
    scrsw_host u_scrsw_host (.clk(clk), .rst(rst), .link(u_scrsw_if), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    scrsw_monitor u_scrsw_monitor (.clk(clk), .rst(rst), .select_word(u_scrsw_if.select_word),
        .trig_bits(u_scrsw_if.trig_bits), .current_word(u_scrsw_if.current_word),
        .switch_strobe(u_scrsw_if.switch_strobe), .notify_ack(u_scrsw_if.notify_ack));
    // Clock and switch counter
    always #4 clk = ~clk;
    always @(posedge clk) if (switch_pulse === 1'b1) pulses <= pulses + 1;
    // ****
    // Helpers
    // ****
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_kind(input scrsw_show_e got, input scrsw_show_e exp);
        chk(32'(got), 32'(exp), "kind");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Entered just after an edge; idle cycle at the end keeps psel from a double drive
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: bus answer missing", $time);
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic scrsw_show_e exp_kind(input logic [15:0] s);
        if (s == SCRSW_SCR_NONE) return SCRSW_SHOW_BLANK;
        if (s == SCRSW_SCR_HIST_OCC) return SCRSW_SHOW_HIST_OCC;
        if (s == SCRSW_SCR_HIST_FREQ) return SCRSW_SHOW_HIST_FREQ;
        if (s == SCRSW_SCR_HOST_CONN) return SCRSW_SHOW_HOST_CONN;
        if (s == GRP) return SCRSW_SHOW_GROUP;
        for (int i = 0; i < 4; i++) if (s[4*i+:4] > 4'h9) return SCRSW_SHOW_INVALID;
        return SCRSW_SHOW_NORMAL;
    endfunction
    function automatic logic [15:0] rand_bcd();
        logic [15:0] v;
        for (int i = 0; i < 4; i++) v[4*i+:4] = 4'($urandom % 10);
        return v;
    endfunction
    // Select a screen, allow more than one poll period, then look at both ends
    task automatic pick(input logic [15:0] s);
        apb(1'b1, SCRSW_REG_SELECT, {16'h0000, s});
        cyc(24);
        chk({16'h0000, shown_screen}, {16'h0000, s}, "shown");
        chk_kind(shown_kind, exp_kind(s));
        apb(1'b0, SCRSW_REG_CURRENT, 32'h0000_0000);
        chk(rd, {16'h0000, s}, "current");
    endtask
    // ****
    // Scenarios
    // ****
    initial begin
        void'($urandom(89322));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pick(16'h0042);
        chk(32'(pulses), 32'h1, "startup");
        foreach (TBL[i]) pick(TBL[i]);
        for (int k = 0; k < 6; k++) pick(k[0] ? rand_bcd() : 16'($urandom));
        pick(16'h0777);
        p0 = pulses;
        apb(1'b1, SCRSW_REG_SELECT, 32'h0000_0777);
        cyc(24);
        chk(32'(pulses - p0), 32'h0, "rewrite");
        pick(16'h0000);
        pick(16'h0777);
        chk(32'(pulses - p0), 32'h2, "reselect");
        pick(16'h1999);
        // Each trigger rises while another screen is up, then falls
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, SCRSW_REG_TRIG, 32'h1 << i);
            cyc(24);
            chk({16'h0000, shown_screen}, {16'h0000, TRIG_SCR[16*i+:16]}, "trig");
            p0 = pulses;
            apb(1'b1, SCRSW_REG_TRIG, 32'h0000_0000);
            cyc(24);
            chk(32'(pulses - p0), 32'h0, "fall");
        end
        // Status, mask and interrupt, then an unmapped offset
        apb(1'b1, SCRSW_REG_STATUS, 32'h0000_0001);
        apb(1'b1, SCRSW_REG_MASK, 32'h0000_0001);
        pick(16'h0123);
        chk({31'h0, irq}, 32'h1, "irq set");
        apb(1'b0, SCRSW_REG_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0001, "status");
        apb(1'b1, SCRSW_REG_STATUS, 32'h0000_0001);
        cyc(2);
        chk({31'h0, irq}, 32'h0, "irq clear");
        apb(1'b1, SCRSW_REG_MASK, 32'h0000_0000);
        pick(16'h0124);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk({rd[30:0], se}, 32'h1, "unmapped");
        give_verdict();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
